// File: hdl/brk_pkg.sv
// Purpose: Shared constants for the serial break and idle transmitter
// Assumes: One 100 MHz clock, asynchronous active-low reset
// Notes:   Break, frame and idle counts are in bit times; BIT_CYC_DEF is in clock cycles
`default_nettype none
package brk_pkg;
  localparam int CLK_HZ          = 100_000_000;
  localparam int BAUD_HZ_DEF     = 115_200;
  localparam int BREAK_BITS_8    = 10;
  localparam int BREAK_BITS_9    = 11;
  localparam int FRAME_BITS_8    = 10;
  localparam int FRAME_BITS_9    = 11;
  localparam int IDLE_BITS_8     = 10;
  localparam int IDLE_BITS_9     = 11;
  localparam int BIT_CYC_DEF     = CLK_HZ / BAUD_HZ_DEF;
  localparam int CNT_W           = 16;
  localparam int BITN_W          = 4;
  localparam logic [1:0] BUF_DEPTH = 2'h2;
endpackage : brk_pkg
`default_nettype wire

// File: hdl/byte_stream_if.sv
// Purpose: Valid/ready carrier for data words between design modules
// Assumes: Single clock domain
// Notes:   Source drives valid and data, sink drives ready
`default_nettype none
interface byte_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// File: hdl/skid_buf.sv
// Purpose: Two-entry buffer in the transmit data path
// Assumes: Single clock, asynchronous active-low reset
// Notes:   Ready toward the source drops only when both entries hold words
`default_nettype none
module skid_buf
  import brk_pkg::*;
#(
  parameter int W = 9
) (
  input  wire logic clock,
  input  wire logic rstn,
  byte_stream_if.snk in_s,
  byte_stream_if.src out_s
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  // Handshakes on both sides
  assign push         = in_s.valid && in_s.ready;
  assign pop          = out_s.valid && out_s.ready;
  assign in_s.ready   = (cnt_r != BUF_DEPTH);
  assign out_s.valid  = (cnt_r != 2'h0);
  assign out_s.data   = mem_r[rp_r];

  // Storage, no reset needed on data
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wp_r] <= in_s.data;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop)  rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule : skid_buf
`default_nettype wire

// File: hdl/serial_break_idle_tx.sv
// Purpose: Transmitter with break and queued-idle generation
// Assumes: Control bits are synchronous to clock
// Notes:   Break is decided only at a frame boundary, never mid-frame
`default_nettype none
module serial_break_idle_tx
  import brk_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYC_DEF
) (
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       tx_on,
  input  wire logic       send_break_bit,
  input  wire logic       nine_bit_sel,
  input  wire logic       in_valid,
  input  wire logic [8:0] in_data,
  output logic            in_ready,
  output logic            tx_line,
  output logic            busy
);
  initial begin
    if (BIT_CYC < 1 || BIT_CYC >= (1 << CNT_W)) begin
      $error("BIT_CYC out of range");
    end
  end

  typedef enum logic [3:0] {
    S_IDLE  = 4'h1,
    S_DATA  = 4'h2,
    S_BRK   = 4'h4,
    S_PRE   = 4'h8
  } st_t;

  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYC - 1);

  st_t               st_r;
  logic [CNT_W-1:0]  cyc_r;
  logic [BITN_W-1:0] bitn_r;
  logic [BITN_W-1:0] last_r;
  logic [10:0]       shf_r;
  logic              ton_d_r;
  logic              idle_q_r;
  logic              bit_end;
  logic              frm_end;
  logic              take;

  byte_stream_if #(.W(9)) fill_s ();
  byte_stream_if #(.W(9)) drain_s ();

  // Two-entry buffer so a busy line loses no word
  skid_buf #(.W(9)) u_buf (
    .clock (clock),
    .rstn  (rstn),
    .in_s  (fill_s),
    .out_s (drain_s)
  );

  // Offer gated by the flopped ready so a lagging ready never drops a word
  assign fill_s.valid = in_valid && in_ready;
  assign fill_s.data  = in_data;

  // Index of the last bit of a frame (length minus one), shared by data, break and idle
  function automatic logic [BITN_W-1:0] frame_len(input logic m9);
    frame_len = m9 ? BITN_W'(FRAME_BITS_9 - 1) : BITN_W'(FRAME_BITS_8 - 1);
  endfunction : frame_len

  assign bit_end = (cyc_r == BIT_LAST);
  assign frm_end = bit_end && (bitn_r == last_r);
  // Data only when no break or idle pending; data waits in the buffer
  assign take    = (st_r == S_IDLE) && tx_on && ton_d_r && !idle_q_r &&
                   !send_break_bit && drain_s.valid;
  assign drain_s.ready = take;

  // Ready through a flop; drops one cycle after each push, so it never
  // promises room that the buffer no longer has
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      in_ready <= 1'b0;
    end else begin
      in_ready <= fill_s.ready && !(fill_s.valid && fill_s.ready);
    end
  end

  // Idle request: tx_on falling then rising queues one idle frame
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      ton_d_r  <= 1'b0;
      idle_q_r <= 1'b0;
    end else begin
      ton_d_r <= tx_on;
      // A rise seen in idle is served at once; elsewhere it waits
      if (tx_on && !ton_d_r && st_r != S_IDLE) begin
        idle_q_r <= 1'b1;
      end else if (st_r == S_IDLE && tx_on) begin
        idle_q_r <= 1'b0;
      end
    end
  end

  // Bit timer and frame sequencer
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      st_r   <= S_IDLE;
      cyc_r  <= '0;
      bitn_r <= '0;
      last_r <= '0;
      shf_r  <= '1;
    end else begin
      case (st_r)
        S_IDLE: begin
          cyc_r  <= '0;
          bitn_r <= '0;
          last_r <= frame_len(nine_bit_sel);
          if (tx_on && (idle_q_r || !ton_d_r)) begin
            st_r  <= S_PRE;
            shf_r <= '1;
          end else if (tx_on && send_break_bit) begin
            st_r  <= S_BRK;
            shf_r <= '0;
          end else if (take) begin
            st_r  <= S_DATA;
            shf_r <= nine_bit_sel ? {1'b1, drain_s.data, 1'b0}
                                  : {2'b11, drain_s.data[7:0], 1'b0};
          end
        end
        S_DATA, S_BRK, S_PRE: begin
          if (bit_end) begin
            cyc_r  <= '0;
            bitn_r <= bitn_r + BITN_W'(1);
            if (st_r == S_DATA) begin
              shf_r <= {1'b1, shf_r[10:1]};
            end
          end else begin
            cyc_r <= cyc_r + CNT_W'(1);
          end
          // Fixed count ends the break; no restretch mid-frame
          if (frm_end) begin
            st_r  <= S_IDLE;
            shf_r <= '1;
          end
        end
        default: begin
          st_r  <= S_IDLE;
          shf_r <= '1;
        end
      endcase
    end
  end

  // Line output from a flop, high when idle
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      tx_line <= 1'b1;
      busy    <= 1'b0;
    end else begin
      tx_line <= (st_r == S_BRK) ? 1'b0 : shf_r[0];
      busy    <= (st_r != S_IDLE);
    end
  end
endmodule : serial_break_idle_tx
`default_nettype wire

// File: tb/brk_checker.sv
// Purpose: Timing assertions on the break and idle transmitter
// Assumes: Small BIT_CYC in simulation
// Notes:   A low run of 10 bit times or more marks a break
`default_nettype none
module brk_checker #(parameter int BIT_CYC = 4) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic tx_on,
  input wire logic send_break_bit,
  input wire logic tx_line,
  input wire logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] low_r;
  // Length of the present low run; data runs stay under a frame
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) low_r <= 16'h0;
    else low_r <= tx_line ? 16'h0 : low_r + 16'h1;
  end
  chk_brk_max: assert property (@(posedge clock) disable iff (!rstn)
    low_r <= 11 * BIT_CYC) else $error("break too long");
  chk_brk_len: assert property (@(posedge clock) disable iff (!rstn)
    $rose(tx_line) && low_r >= 10 * BIT_CYC |->
    low_r == 10 * BIT_CYC || low_r == 11 * BIT_CYC)
    else $error("break length wrong");
  chk_brk_again: assert property (@(posedge clock) disable iff (!rstn)
    $rose(tx_line) && low_r >= 10 * BIT_CYC && send_break_bit && tx_on
    |-> ##[1:6] !tx_line) else $error("break not repeated");
  chk_brk_low: assert property (@(posedge clock) disable iff (!rstn)
    $fell(tx_line) && $past(send_break_bit, 2) && $past(tx_on, 2)
    |-> !tx_line [*8]) else $error("break not held low");
  chk_idle_start: assert property (@(posedge clock) disable iff (!rstn)
    $rose(tx_on) && !busy |-> ##[1:4] (busy && tx_line))
    else $error("idle frame not queued");
  chk_idle_high: assert property (@(posedge clock) disable iff (!rstn)
    $rose(busy) && tx_line |-> tx_line [*8]) else $error("idle not high");
endmodule : brk_checker
bind serial_break_idle_tx brk_checker #(.BIT_CYC(BIT_CYC)) i_chk (
  .clock(clock), .rstn(rstn), .tx_on(tx_on),
  .send_break_bit(send_break_bit), .tx_line(tx_line), .busy(busy));
`default_nettype wire

// File: tb/line_rx_model.sv
// Purpose: Far-end serial receiver, decodes words and times breaks
// Assumes: Eight data bits for words
// Notes:   A zero stop bit means a break, not a word
`default_nettype none
module line_rx_model #(parameter int BIT_CYC = 4) (
  input  wire logic clock,
  input  wire logic rstn,
  input  wire logic line,
  output logic [15:0] low_len,
  output logic [7:0]  word,
  output int          n_word,
  output int          n_brk
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] run_r;
  logic [8:0]  sh;
  // Break counted when the line comes back high
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      run_r <= 16'h0;
      n_brk <= 0;
      low_len <= 16'h0;
    end else begin
      run_r <= line ? 16'h0 : run_r + 16'h1;
      if (line && run_r >= 10 * BIT_CYC) begin
        n_brk <= n_brk + 1;
        low_len <= run_r;
      end
    end
  end
  // Mid-bit sampling, LSB first
  initial begin
    n_word = 0;
    word = 8'h00;
    forever begin
      @(negedge line);
      repeat (BIT_CYC / 2) @(posedge clock);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT_CYC) @(posedge clock);
        sh = {line, sh[8:1]};
      end
      if (sh[8]) begin
        word = sh[7:0];
        n_word++;
      end
    end
  end
endmodule : line_rx_model
`default_nettype wire

// File: tb/tb_serial_break_idle_tx.sv
// Purpose: Self-checking bench for break and idle generation
// Assumes: BIT_CYC of 4
// Notes:   Software order is mimicked by the stimulus
`default_nettype none
module tb_serial_break_idle_tx;
  timeunit 1ns;
  timeprecision 1ps;
  import brk_pkg::*;
  localparam int B = 4;
  logic clock = 0, rstn = 0, tx_on = 0, brk_req = 0, nine = 0;
  logic in_valid = 0, full = 0, in_ready, tx_line, busy;
  logic [8:0] in_data = 9'h000;
  logic [15:0] low_len;
  logic [7:0] word;
  logic [7:0] exp_q[$];
  int n_word, n_brk, b0, num_errors = 0, comparisons = 0, seed = 44203;
  serial_break_idle_tx #(.BIT_CYC(B)) i_dut (.clock(clock), .rstn(rstn),
    .tx_on(tx_on), .send_break_bit(brk_req), .nine_bit_sel(nine),
    .in_valid(in_valid), .in_data(in_data), .in_ready(in_ready),
    .tx_line(tx_line), .busy(busy));
  line_rx_model #(.BIT_CYC(B)) i_rx (.clock(clock), .rstn(rstn),
    .line(tx_line), .low_len(low_len), .word(word), .n_word(n_word),
    .n_brk(n_brk));
  initial forever #5 clock = ~clock;
  function automatic logic [15:0] brk_len(input logic n);
    return 16'((n ? BREAK_BITS_9 : BREAK_BITS_8) * B);
  endfunction : brk_len
  task automatic check(input logic ok, input string m);
    comparisons++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask : check
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  // Busy low for 8 cycles means all frames are out
  task automatic settle;
    int q;
    q = 0;
    while (q < 8) begin
      @(negedge clock);
      q = (busy === 1'b0) ? q + 1 : 0;
    end
  endtask : settle
  always @(n_word) if (n_word > 0) check(word === exp_q.pop_front(), "word");
  initial begin
    repeat (12) @(negedge clock);
    check(tx_line === 1'b1 && busy === 1'b0, "reset state");
    rstn = 1;
    @(negedge clock);
    tx_on = 1;
    settle;
    // Random burst overruns the two entries; held words are not lost
    for (int i = 0; i < 6; i++) begin
      in_data = {1'b0, 8'($random(seed))};
      in_valid = 1;
      while (in_ready !== 1'b1) begin
        full = 1;
        @(negedge clock);
      end
      exp_q.push_back(in_data[7:0]);
      @(negedge clock);
    end
    in_valid = 0;
    settle;
    check(full === 1'b1 && n_word === 6, "burst");
    $display("test burst done");
    // Idle request then one break, both frame lengths
    for (int m = 0; m < 2; m++) begin
      nine = m[0];
      b0 = n_brk;
      tx_on = 0;
      @(negedge clock);
      tx_on = 1;
      brk_req = 1;
      while (tx_line !== 1'b0) @(negedge clock);
      brk_req = 0;
      settle;
      check(n_brk === b0 + 1, "single break");
      check(low_len === brk_len(nine), "break length");
      $display("test break %0d done", m);
    end
    // Held request repeats; clearing mid-break keeps full length
    b0 = n_brk;
    brk_req = 1;
    while (n_brk < b0 + 1) @(negedge clock);
    while (tx_line !== 1'b0) @(negedge clock);
    brk_req = 0;
    settle;
    check(n_brk === b0 + 2, "repeat count");
    check(low_len === brk_len(nine), "repeat length");
    $display("test repeat done");
    results;
  end
  initial begin
    #100000;
    num_errors++;
    $display("CHECK FAILED %0t watchdog", $time);
    results;
  end
endmodule : tb_serial_break_idle_tx
`default_nettype wire
